/* src/safety_status_map.vh */
/*
 bit positions, offsets and constants of the safety option status word.
 assumes inclusion by design files only; definitions only.
*/
`ifndef SAFETY_STATUS_MAP_VH
`define SAFETY_STATUS_MAP_VH

// register word offsets on the plain port (byte addresses)
`define OFS_STATUS_WORD 8'h00
`define OFS_CTRL 8'h04
`define OFS_EVT_CLEAR 8'h08
`define OFS_CRED_LO 8'h0c
`define OFS_RESET_CMD 8'h10
`define OFS_PARAM 8'h14
`define OFS_SEL_STATUS 8'h18

// status word bit positions
`define BIT_NORMAL 0
`define BIT_SELF_TEST 1
`define BIT_TORQUE_OFF 2
`define BIT_TIMED_STOP 3
`define BIT_OUT_LOW 8
`define BIT_INIT 9
`define BIT_ACK_REQ 10
`define BIT_INT_FAIL 11
`define BIT_RESET_REQ 12
`define BIT_PEND_FAILSAFE 13
`define BIT_EXT_FAIL 14
`define BIT_FUNC_PEND 15
`define BIT_GEN_RESET 16
`define BIT_CUST_CONF 17
`define BIT_CUST_ABORT 18
`define BIT_CUST_REQ 19
`define BIT_TEST_WARN 21
`define ERR_LSB 24
`define ERR_MSB 31

// selectable status word choices
`define SEL_FUNC_ACTIVE 8'h5a
`define SEL_RESET_REQ 8'h5b

// factory default credential and parameters
`define CRED_DEFAULT 32'h00bc614e
`define PARAM_DEFAULT 32'h00000000
`define CTRL_RESET 8'h00

`endif

/* src/pin_sync.v */
/*
 three-stage synchroniser for a bus of asynchronous inputs.
 assumes one clock; change taken once stages two and three agree.
*/
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] s1_ff;
    reg [WIDTH-1:0] s2_ff;
    reg [WIDTH-1:0] s3_ff;
    reg [WIDTH-1:0] out_ff;
    reg [WIDTH-1:0] nxt_out;
    integer i;

    always @*
    begin
        nxt_out = out_ff;
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (s2_ff[i] == s3_ff[i])
            begin
                nxt_out[i] = s3_ff[i];
            end
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= {WIDTH{1'b0}};
            s2_ff <= {WIDTH{1'b0}};
            s3_ff <= {WIDTH{1'b0}};
            out_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign level_out = out_ff;
endmodule

/* src/event_latch.v */
/*
 sticky event bits: set by a pulse, cleared by software; set wins.
 assumes event pulses on the same clock.
*/
`timescale 1ns/1ps
module event_latch #(
    parameter WIDTH = 5
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] evt_set,
    input wire [WIDTH-1:0] evt_clr,
    output wire [WIDTH-1:0] evt_q
);
    reg [WIDTH-1:0] evt_ff;
    wire [WIDTH-1:0] nxt_evt;

    assign nxt_evt = (evt_ff & ~evt_clr) | evt_set;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            evt_ff <= nxt_evt;
        end
    end

    assign evt_q = evt_ff;
endmodule

/* src/safety_option_status_word.v */
/*
 safety option status word: assembles the read-only 32-bit status of a
 drive safety option from the option's state inputs, latches its events,
 drives one selectable status bit, and handles the credential reset that
 restores the option parameters.
 assumes state inputs are asynchronous levels and event inputs are
 one-cycle pulses from logic on clk_sys; register port as plain strobes.
*/
// Our own choices: the plain strobed port and the register addresses.
// Summary of operation
// - credential reset restores all parameters to default
// - selection 91 drives reset-required bit out
// - selection 90 drives safe-function-active bit out
// - status word read-only, writes have no effect
// - bit 0 high only in normal operation
// - bit 1 shows power-up self test
// - bit 2 shows torque off active
// - bit 3 shows timed controlled stop active
// - bit 8 inverted safe output level
// - bit 9 shows initialized state
// - bit 10 shows acknowledge request
// - bit 11 shows internal failure
// - bit 12 shows reset required
// - bit 13 pending fail-safe, set at power-up
// - bit 14 shows external failure
// - bit 15 shows safe function pending
// - bit 16 marks general reset done
// - bits 17-19 customization confirm, abort, request
// - bit 21 marks self-test warning
// - bits 24-31 carry error code
// - only the active safety function reported
`timescale 1ns/1ps
`include "safety_status_map.vh"
module safety_option_status_word #(
    parameter ERR_WIDTH = 8
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire power_up_self_test,
    input wire torque_off_function,
    input wire timed_controlled_stop,
    input wire safe_output_high,
    input wire option_initialized,
    input wire ack_requested,
    input wire internal_failure,
    input wire external_failure,
    input wire function_pending,
    input wire warning_active,
    input wire failsafe_reaction,
    input wire failsafe_cleared,
    input wire [ERR_WIDTH-1:0] error_code,
    input wire general_reset_evt,
    input wire cust_confirm_evt,
    input wire cust_abort_evt,
    input wire cust_request_evt,
    input wire test_warning_evt,
    output wire selectable_status_word,
    output reg [31:0] option_param,
    output reg param_restore
);
    localparam ST_IDLE = 1'b0;
    localparam ST_ARMED = 1'b1;

    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_n;
    wire [9:0] lvl;
    reg [ERR_WIDTH-1:0] err_ff;
    reg [ERR_WIDTH-1:0] err_s1_ff;
    reg [ERR_WIDTH-1:0] err_s2_ff;
    reg [ERR_WIDTH-1:0] err_s3_ff;
    reg [ERR_WIDTH-1:0] nxt_err;
    reg pend_fs_ff;
    reg nxt_pend_fs;
    reg failsafe_ff;
    reg reset_req_ff;
    reg nxt_reset_req;
    reg [7:0] sel_ff;
    reg [31:0] cred_ff;
    reg [31:0] nxt_cred;
    reg [31:0] param_ff;
    reg [31:0] nxt_param;
    reg state_ff;
    reg nxt_state;
    reg restore_ff;
    reg nxt_restore;
    reg sel_out_ff;
    reg nxt_sel_out;
    reg [31:0] nxt_rdata;
    reg [31:0] status_word;
    reg [4:0] evt_clr;
    wire [4:0] evt_q;
    wire torque_off_s;
    wire timed_stop_s;
    wire func_active;
    wire normal_op;
    integer k;

    function is_wr;
        input [7:0] addr;
        input wr;
        input [7:0] ofs;
        begin
            is_wr = wr && (addr == ofs);
        end
    endfunction

    // reset release through two flip-flops
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    assign rst_n = rst_s2_ff;

    pin_sync #(
        .WIDTH(10)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in({power_up_self_test, torque_off_function, timed_controlled_stop,
            safe_output_high, option_initialized, ack_requested, internal_failure,
            external_failure, function_pending, warning_active}),
        .level_out(lvl)
    );

    event_latch #(
        .WIDTH(5)
    ) u_evt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .evt_set({test_warning_evt, cust_request_evt, cust_abort_evt,
            cust_confirm_evt, general_reset_evt}),
        .evt_clr(evt_clr),
        .evt_q(evt_q)
    );

    always @*
    begin
        evt_clr = 5'h00;
        if (is_wr(reg_addr, reg_wr, `OFS_EVT_CLEAR))
        begin
            evt_clr = {reg_wdata[`BIT_TEST_WARN], reg_wdata[`BIT_CUST_REQ],
                reg_wdata[`BIT_CUST_ABORT], reg_wdata[`BIT_CUST_CONF],
                reg_wdata[`BIT_GEN_RESET]};
        end
    end

    // torque off takes precedence, one function reported
    assign torque_off_s = lvl[8];
    assign timed_stop_s = lvl[7] & ~lvl[8];
    assign func_active = torque_off_s | lvl[7];

    // normal only with nothing active, pending or warning
    assign normal_op = ~(func_active | lvl[1] | failsafe_ff | pend_fs_ff | lvl[0]
        | lvl[9] | lvl[3] | lvl[2]);

    // error code synchronised, taken when stable
    always @*
    begin
        nxt_err = err_ff;
        if (err_s2_ff == err_s3_ff)
        begin
            nxt_err = err_s3_ff;
        end
    end

    // pending fail-safe entered at power-up, left on clear
    always @*
    begin
        nxt_pend_fs = pend_fs_ff;
        if (failsafe_cleared)
        begin
            nxt_pend_fs = 1'b0;
        end
    end

    // reset required after fault or customization confirm
    always @*
    begin
        nxt_reset_req = reset_req_ff;
        if (evt_q[0])
        begin
            nxt_reset_req = 1'b0;
        end
        if (lvl[3] || lvl[2] || cust_confirm_evt)
        begin
            nxt_reset_req = 1'b1;
        end
    end

    // credential reset sequence
    always @*
    begin
        nxt_state = state_ff;
        nxt_cred = cred_ff;
        nxt_param = param_ff;
        nxt_restore = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                // default or current credential must be given first
                if (is_wr(reg_addr, reg_wr, `OFS_CRED_LO)
                    && (reg_wdata == `CRED_DEFAULT || reg_wdata == cred_ff))
                begin
                    nxt_state = ST_ARMED;
                end
                if (is_wr(reg_addr, reg_wr, `OFS_PARAM))
                begin
                    nxt_param = reg_wdata;
                end
            end
            ST_ARMED:
            begin
                if (is_wr(reg_addr, reg_wr, `OFS_RESET_CMD) && reg_wdata[0])
                begin
                    nxt_param = `PARAM_DEFAULT;
                    nxt_cred = `CRED_DEFAULT;
                    nxt_restore = 1'b1;
                    nxt_state = ST_IDLE;
                end
                else if (is_wr(reg_addr, reg_wr, `OFS_CRED_LO))
                begin
                    // new credential accepted while armed
                    nxt_cred = reg_wdata;
                    nxt_state = ST_IDLE;
                end
                else if (is_wr(reg_addr, reg_wr, `OFS_PARAM))
                begin
                    nxt_param = reg_wdata;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // status word assembly
    always @*
    begin
        status_word = 32'h00000000;
        status_word[`BIT_NORMAL] = normal_op;
        status_word[`BIT_SELF_TEST] = lvl[9];
        status_word[`BIT_TORQUE_OFF] = torque_off_s;
        status_word[`BIT_TIMED_STOP] = timed_stop_s;
        status_word[`BIT_OUT_LOW] = ~lvl[6];
        status_word[`BIT_INIT] = lvl[5];
        status_word[`BIT_ACK_REQ] = lvl[4];
        status_word[`BIT_INT_FAIL] = lvl[3];
        status_word[`BIT_RESET_REQ] = reset_req_ff;
        status_word[`BIT_PEND_FAILSAFE] = pend_fs_ff;
        status_word[`BIT_EXT_FAIL] = lvl[2];
        status_word[`BIT_FUNC_PEND] = lvl[1];
        status_word[`BIT_GEN_RESET] = evt_q[0];
        status_word[`BIT_CUST_CONF] = evt_q[1];
        status_word[`BIT_CUST_ABORT] = evt_q[2];
        status_word[`BIT_CUST_REQ] = evt_q[3];
        status_word[`BIT_TEST_WARN] = evt_q[4];
        for (k = 0; k < ERR_WIDTH && k < 8; k = k + 1)
        begin
            status_word[`ERR_LSB + k] = err_ff[k];
        end
        // reserved bits stay zero by default
    end

    // selectable bit
    always @*
    begin
        case (sel_ff)
            `SEL_RESET_REQ: nxt_sel_out = reset_req_ff;
            `SEL_FUNC_ACTIVE: nxt_sel_out = func_active;
            default: nxt_sel_out = 1'b0;
        endcase
    end

    // read data mux; status word has no write path
    always @*
    begin
        nxt_rdata = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                `OFS_STATUS_WORD: nxt_rdata = status_word;
                `OFS_CTRL: nxt_rdata = {24'h000000, sel_ff};
                `OFS_PARAM: nxt_rdata = param_ff;
                `OFS_SEL_STATUS: nxt_rdata = {31'h00000000, state_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_s1_ff <= {ERR_WIDTH{1'b0}};
            err_s2_ff <= {ERR_WIDTH{1'b0}};
            err_s3_ff <= {ERR_WIDTH{1'b0}};
            err_ff <= {ERR_WIDTH{1'b0}};
            pend_fs_ff <= 1'b1;
            failsafe_ff <= 1'b0;
            reset_req_ff <= 1'b0;
            sel_ff <= `CTRL_RESET;
            cred_ff <= `CRED_DEFAULT;
            param_ff <= `PARAM_DEFAULT;
            state_ff <= ST_IDLE;
            restore_ff <= 1'b0;
            sel_out_ff <= 1'b0;
            reg_rdata <= 32'h00000000;
            option_param <= `PARAM_DEFAULT;
            param_restore <= 1'b0;
        end
        else
        begin
            err_s1_ff <= error_code;
            err_s2_ff <= err_s1_ff;
            err_s3_ff <= err_s2_ff;
            err_ff <= nxt_err;
            pend_fs_ff <= nxt_pend_fs;
            failsafe_ff <= failsafe_reaction;
            reset_req_ff <= nxt_reset_req;
            if (is_wr(reg_addr, reg_wr, `OFS_CTRL))
            begin
                sel_ff <= reg_wdata[7:0];
            end
            cred_ff <= nxt_cred;
            param_ff <= nxt_param;
            state_ff <= nxt_state;
            restore_ff <= nxt_restore;
            sel_out_ff <= nxt_sel_out;
            reg_rdata <= nxt_rdata;
            option_param <= nxt_param;
            param_restore <= restore_ff;
        end
    end

    assign selectable_status_word = sel_out_ff;
endmodule

/* verification/safety_status_checker.sv */
/*
 port checker for the safety option status word.
 assumes binding to the status word top module; one clock domain.
*/
`timescale 1ns/1ps
module safety_status_checker #(
    parameter ERR_WIDTH = 8
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire [ERR_WIDTH-1:0] error_code,
    input wire power_up_self_test,
    input wire torque_off_function,
    input wire safe_output_high,
    input wire internal_failure,
    input wire external_failure,
    input wire [31:0] option_param,
    input wire param_restore
);
    wire [ERR_WIDTH+3:0] lvl = {error_code, power_up_self_test, torque_off_function,
        safe_output_high, internal_failure, external_failure};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence st_rd;
        reg_rd && reg_addr == 8'h00;
    endsequence
    // level inputs settled long enough to show
    sequence quiet;
        $stable(lvl) [*6];
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    chk_reserved_zero: assert property (st_rd |=> (reg_rdata & 32'h00d000f0) == 32'h0)
        else $error("reserved status bit set");
    chk_normal_only: assert property (st_rd |=>
        !reg_rdata[0] || (reg_rdata & 32'h0000e80e) == 0)
        else $error("normal flag beside an active state");
    chk_one_function: assert property (st_rd |=> !(reg_rdata[2] && reg_rdata[3]))
        else $error("two safety functions reported");
    chk_err_code: assert property (quiet ##0 st_rd |=>
        reg_rdata[31:24] == $past(error_code))
        else $error("error code field differs from input");
    chk_level_bits: assert property (quiet ##0 st_rd |=>
        reg_rdata[2] == $past(torque_off_function) && reg_rdata[1] == $past(power_up_self_test)
        && reg_rdata[11] == $past(internal_failure) && reg_rdata[14] == $past(external_failure))
        else $error("status level bit differs from input");
    chk_out_inverted: assert property (quiet ##0 st_rd |=>
        reg_rdata[8] == !$past(safe_output_high))
        else $error("safe output bit not inverted");
    chk_restore_default: assert property (param_restore |-> option_param == 32'h0)
        else $error("parameters not at default on restore");
    chk_restore_width: assert property (param_restore |=> !param_restore)
        else $error("restore pulse longer than one cycle");
endmodule

bind safety_option_status_word safety_status_checker #(.ERR_WIDTH(ERR_WIDTH)) chk (
    .clk_sys, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .error_code, .power_up_self_test,
    .torque_off_function, .safe_output_high, .internal_failure, .external_failure,
    .option_param, .param_restore);

/* verification/fieldbus_reader.sv */
/*
 model of the status reader on the plain register port.
 assumes one clock; reads answer the cycle after the strobe.
*/
`timescale 1ns/1ps
module fieldbus_reader (
    input wire clk_sys,
    input wire [31:0] reg_rdata,
    output reg [7:0] reg_addr,
    output reg [31:0] reg_wdata,
    output reg reg_wr,
    output reg reg_rd
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // released data shows no stale value
        reg_wdata <= ~d;
    endtask
    task rd(input [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
endmodule

/* verification/safety_option_status_word_tb_top.sv */
/*
 self-checking bench of the safety option status word.
 assumes the reader model drives the register port.
*/
`timescale 1ns/1ps
module safety_option_status_word_tb_top;
    reg clk_sys = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] lv = 8'h0;
    reg [4:0] ev = 5'h0;
    reg safe_output_high = 1'b0;
    reg warning_active = 1'b0;
    reg failsafe_reaction = 1'b0;
    reg failsafe_cleared = 1'b0;
    reg [7:0] error_code = 8'h00;
    wire [7:0] reg_addr;
    wire [31:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    wire [31:0] reg_rdata;
    wire selectable_status_word;
    wire [31:0] option_param;
    wire param_restore;
    int n_fail = 0;
    int n_tests = 0;
    int pos[8] = '{1, 2, 3, 9, 10, 11, 14, 15};
    int epos[5] = '{16, 17, 18, 19, 21};
    logic [31:0] w;
    logic seen;

    initial forever #20 clk_sys = ~clk_sys;

    safety_option_status_word DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_up_self_test(lv[0]), .torque_off_function(lv[1]), .timed_controlled_stop(lv[2]),
        .safe_output_high(safe_output_high), .option_initialized(lv[3]), .ack_requested(lv[4]),
        .internal_failure(lv[5]), .external_failure(lv[6]), .function_pending(lv[7]),
        .warning_active(warning_active), .failsafe_reaction(failsafe_reaction),
        .failsafe_cleared(failsafe_cleared), .error_code(error_code),
        .general_reset_evt(ev[0]), .cust_confirm_evt(ev[1]), .cust_abort_evt(ev[2]),
        .cust_request_evt(ev[3]), .test_warning_evt(ev[4]),
        .selectable_status_word(selectable_status_word), .option_param(option_param),
        .param_restore(param_restore));

    fieldbus_reader host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    task complete_run();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task st();
        host.rd(8'h00, w);
    endtask
    task pulse_ev(input [4:0] m);
        ev <= m;
        @(posedge clk_sys);
        ev <= 5'h0;
    endtask
    task t_levels();
        st();
        cmp(w, 32'h00002100);
        for (int i = 0; i < 8; i++)
        begin
            lv <= 8'h1 << i;
            cyc(6);
            st();
            cmp((w >> pos[i]) & 32'h1, 32'h1);
            lv <= 8'h0;
            cyc(6);
            st();
            cmp((w >> pos[i]) & 32'h1, 32'h0);
        end
        lv <= 8'h06;
        cyc(6);
        st();
        cmp({30'h0, w[3:2]}, 32'h1);
        lv <= 8'h0;
        safe_output_high <= 1'b1;
        error_code <= 8'ha5;
        cyc(6);
        st();
        cmp(w & 32'hff000100, 32'ha5000000);
        error_code <= 8'h00;
    endtask
    task t_events();
        for (int i = 4; i >= 0; i--)
        begin
            pulse_ev(5'h1 << i);
            st();
            cmp((w >> epos[i]) & 32'h1, 32'h1);
        end
        host.wr(8'h08, 32'h002f0000);
        st();
        cmp(w & 32'h002f0000, 32'h0);
    endtask
    task t_normal();
        failsafe_cleared <= 1'b1;
        @(posedge clk_sys);
        failsafe_cleared <= 1'b0;
        cyc(6);
        st();
        cmp(w, 32'h1);
        host.wr(8'h00, 32'hffffffff);
        st();
        cmp(w, 32'h1);
        host.rd(8'h1c, w);
        cmp(w, 32'h0);
        warning_active <= 1'b1;
        cyc(6);
        st();
        cmp({31'h0, w[0]}, 32'h0);
        warning_active <= 1'b0;
        cyc(6);
        failsafe_reaction <= 1'b1;
        cyc(2);
        st();
        cmp({31'h0, w[0]}, 32'h0);
        failsafe_reaction <= 1'b0;
        cyc(6);
        st();
        cmp(w, 32'h1);
    endtask
    task t_select();
        host.wr(8'h04, 32'h5b);
        pulse_ev(5'h02);
        cyc(3);
        cmp({31'h0, selectable_status_word}, 32'h1);
        pulse_ev(5'h01);
        cyc(3);
        cmp({31'h0, selectable_status_word}, 32'h0);
        host.wr(8'h04, 32'h5a);
        host.rd(8'h04, w);
        cmp(w, 32'h5a);
        lv <= 8'h02;
        cyc(6);
        cmp({31'h0, selectable_status_word}, 32'h1);
        lv <= 8'h00;
        cyc(6);
        cmp({31'h0, selectable_status_word}, 32'h0);
    endtask
    task t_cred();
        host.wr(8'h14, 32'h0000beef);
        host.wr(8'h10, 32'h1);
        cyc(2);
        cmp(option_param, 32'h0000beef);
        host.wr(8'h0c, 32'h00bc614e);
        host.wr(8'h10, 32'h1);
        seen = 1'b0;
        for (int k = 0; k < 8 && !seen; k++)
        begin
            @(posedge clk_sys);
            seen = param_restore;
        end
        cmp({31'h0, seen}, 32'h1);
        cmp(option_param, 32'h0);
        host.wr(8'h0c, 32'h00bc614e);
        host.rd(8'h18, w);
        cmp(w, 32'h1);
        host.wr(8'h0c, 32'h13572468);
        host.rd(8'h18, w);
        cmp(w, 32'h0);
        host.rd(8'h14, w);
        cmp(w, 32'h0);
    endtask

    initial
    begin
        #(40 * 6000);
        n_fail++;
        complete_run();
    end
    initial
    begin
        cyc(6);
        rst_b <= 1'b1;
        cyc(4);
        t_levels();
        t_events();
        t_normal();
        t_select();
        t_cred();
        complete_run();
    end
endmodule
